//--- pic_consts.svh
`ifndef PIC_CONSTS_SVH
`define PIC_CONSTS_SVH

// ============================================================
// Command word decode
`define PIC_W1_MARK_BIT   4
`define PIC_W1_IC4_BIT    0
`define PIC_W1_LEVEL_TRIGGER_SELECT_BIT   3
`define PIC_W1_ADI_BIT    2
`define PIC_W4_UPM_BIT    0
`define PIC_W4_AUTO_END_OF_INTERRUPT_BIT   1
`define PIC_W4_SPECIAL_NESTING_ENABLE_BIT   4
`define PIC_W2_R_BIT      7
`define PIC_W2_SL_BIT     6
`define PIC_W2_EOI_BIT    5
`define PIC_W3_MARK_BIT   3
`define PIC_W3_P_BIT      2
`define PIC_W3_READBACK_ENABLE_BIT   1
`define PIC_W3_RIS_BIT    0
`define PIC_CALL_OPCODE   8'hcd
`define PIC_RESET_MASK    8'hff
`define PIC_RESET_LOWEST  3'h7
`endif

//--- pic_pkg.sv
package pic_pkg;
  // ============================================================
  // Types
  typedef enum logic [4:0] {
    PIC_ST_IDLE = 5'h01,
    PIC_ST_W2   = 5'h02,
    PIC_ST_W3   = 5'h04,
    PIC_ST_W4   = 5'h08,
    PIC_ST_RUN  = 5'h10
  } pic_init_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       a0;
    logic [7:0] data;
  } pic_host_cmd_t;
endpackage

//--- pic_top.sv
`include "pic_consts.svh"

module pic_top (
  // Clock and reset
  input  wire  logic                   clk,
  input  wire  logic                   nrst,
  // Host command port
  input  wire  pic_pkg::pic_host_cmd_t cmd,
  output logic [7:0]                   rd_data_q,
  // Acknowledge and data bus
  input  wire  logic                   inta_pulse,
  output logic [7:0]                   bus_data_q,
  output logic                         bus_data_oe_n_q,
  // Requests and interrupt
  input  wire  logic [7:0]             request_input,
  output logic                         int_q
);
  import pic_pkg::*;

  // ============================================================
  // State
  pic_init_state_t init_q;
  logic [7:0] w1_q, w2_q, w4_q;
  logic       single_q;
  logic [7:0] mask_bits_q;
  logic [7:0] pending_request_register_q;
  logic [7:0] in_service_register_q;
  logic [7:0] req_prev_q;
  logic [2:0] lowest_q;
  logic       rot_auto_end_of_interrupt_q;
  logic       readback_select_q;
  logic [1:0] ack_cnt_q;
  logic [2:0] ack_lvl_q;

  logic       is_w1, is_w3, is_w2cmd, is_data;
  logic       upm16, auto_end_of_interrupt, special_nesting_enable;
  logic [7:0] edge_seen;
  logic       req_any;
  logic [2:0] req_lvl;
  logic       isr_any;
  logic [2:0] isr_lvl;
  logic       take;
  logic [7:0] vector;

  assign is_w1    = cmd.wr & ~cmd.a0 & cmd.data[`PIC_W1_MARK_BIT];
  assign is_w3    = cmd.wr & ~cmd.a0 & ~cmd.data[`PIC_W1_MARK_BIT] & cmd.data[`PIC_W3_MARK_BIT];
  assign is_w2cmd = cmd.wr & ~cmd.a0 & ~cmd.data[`PIC_W1_MARK_BIT] & ~cmd.data[`PIC_W3_MARK_BIT];
  assign is_data  = cmd.wr & cmd.a0;
  assign upm16    = w4_q[`PIC_W4_UPM_BIT];
  assign auto_end_of_interrupt     = w4_q[`PIC_W4_AUTO_END_OF_INTERRUPT_BIT];
  assign special_nesting_enable     = w4_q[`PIC_W4_SPECIAL_NESTING_ENABLE_BIT];

  // ============================================================
  // Priority resolve, rotating from the level after the lowest
  always_comb begin
    logic [2:0] lv;
    logic       stop;
    req_any = 1'b0;
    req_lvl = 3'h0;
    isr_any = 1'b0;
    isr_lvl = 3'h0;
    stop    = 1'b0;
    lv      = 3'h0;
    for (int i = 1; i <= 8; i++) begin
      lv = 3'(lowest_q + 3'(i));
      if (!stop && in_service_register_q[lv] && !isr_any) begin
        isr_any = 1'b1;
        isr_lvl = lv;
      end
      // Same level may re-interrupt only with special nesting
      if (!stop && !req_any && pending_request_register_q[lv]
          && !mask_bits_q[lv]
          && (!in_service_register_q[lv] || special_nesting_enable)) begin
        req_any = 1'b1;
        req_lvl = lv;
      end
      if (in_service_register_q[lv])
        stop = 1'b1;
    end
  end

  // Edge mode needs the low-to-high step; level mode takes the level
  assign edge_seen = w1_q[`PIC_W1_LEVEL_TRIGGER_SELECT_BIT] ? request_input
                                            : (request_input & ~req_prev_q);
  assign take = (init_q == PIC_ST_RUN) & inta_pulse & (ack_cnt_q == 2'h0);

  // ============================================================
  // Initialization sequence, host orders the words
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      init_q   <= PIC_ST_IDLE;
      w1_q     <= 8'h00;
      w2_q     <= 8'h00;
      w4_q     <= 8'h00;
      single_q <= 1'b1;
    end else if (is_w1) begin
      init_q   <= PIC_ST_W2;
      w1_q     <= cmd.data;
      w4_q     <= 8'h00;
      single_q <= cmd.data[1];
    end else if (is_data) begin
      unique case (init_q)
        PIC_ST_W2: begin
          w2_q   <= cmd.data;
          init_q <= !single_q ? PIC_ST_W3
                  : (w1_q[`PIC_W1_IC4_BIT] ? PIC_ST_W4 : PIC_ST_RUN);
        end
        PIC_ST_W3: begin
          init_q <= w1_q[`PIC_W1_IC4_BIT] ? PIC_ST_W4 : PIC_ST_RUN;
        end
        PIC_ST_W4: begin
          w4_q   <= cmd.data;
          init_q <= PIC_ST_RUN;
        end
        PIC_ST_IDLE, PIC_ST_RUN: begin
        end
      endcase
    end
  end

  // ============================================================
  // Mask register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      mask_bits_q <= `PIC_RESET_MASK;
    else if (is_w1)
      mask_bits_q <= 8'h00;
    else if (is_data && init_q == PIC_ST_RUN)
      mask_bits_q <= cmd.data;
  end

  // ============================================================
  // Pending requests; a new edge wins over acknowledge clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      req_prev_q                 <= 8'h00;
      pending_request_register_q <= 8'h00;
    end else begin
      req_prev_q <= request_input;
      if (is_w1)
        pending_request_register_q <= 8'h00;
      else begin
        logic [7:0] nxt;
        nxt = pending_request_register_q;
        if (w1_q[`PIC_W1_LEVEL_TRIGGER_SELECT_BIT])
          nxt = request_input;
        if (take)
          nxt[req_lvl] = 1'b0;
        pending_request_register_q <= nxt | edge_seen;
      end
    end
  end

  // ============================================================
  // In-service, EOI commands and priority rotation
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      in_service_register_q <= 8'h00;
      lowest_q              <= `PIC_RESET_LOWEST;
      rot_auto_end_of_interrupt_q            <= 1'b0;
    end else if (is_w1) begin
      in_service_register_q <= 8'h00;
      lowest_q              <= `PIC_RESET_LOWEST;
      rot_auto_end_of_interrupt_q            <= 1'b0;
    end else if (is_w2cmd) begin
      if (cmd.data[`PIC_W2_EOI_BIT]) begin
        if (cmd.data[`PIC_W2_SL_BIT]) begin
          in_service_register_q[cmd.data[2:0]] <= 1'b0;
          if (cmd.data[`PIC_W2_R_BIT])
            lowest_q <= cmd.data[2:0];
        end else if (isr_any) begin
          in_service_register_q[isr_lvl] <= 1'b0;
          if (cmd.data[`PIC_W2_R_BIT])
            lowest_q <= isr_lvl;
        end
      end else if (cmd.data[`PIC_W2_SL_BIT]) begin
        if (cmd.data[`PIC_W2_R_BIT])
          lowest_q <= cmd.data[2:0];
      end else
        rot_auto_end_of_interrupt_q <= cmd.data[`PIC_W2_R_BIT];
    end else if (take && req_any) begin
      // Auto mode never marks the level in service
      if (!auto_end_of_interrupt)
        in_service_register_q[req_lvl] <= 1'b1;
      else if (rot_auto_end_of_interrupt_q)
        lowest_q <= req_lvl;
    end
  end

  // ============================================================
  // Acknowledge sequence and vector
  always_comb begin
    if (upm16)
      vector = {w2_q[7:3], ack_lvl_q};
    else if (ack_cnt_q == 2'h1)
      vector = w1_q[`PIC_W1_ADI_BIT]
             ? {w1_q[7:5], ack_lvl_q, 2'h0}
             : {w1_q[7:6], ack_lvl_q, 3'h0};
    else
      vector = w2_q;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_cnt_q       <= 2'h0;
      ack_lvl_q       <= 3'h7;
      bus_data_q      <= 8'h00;
      bus_data_oe_n_q <= 1'b1;
    end else if (take) begin
      // Spurious acknowledge answers with level seven
      ack_lvl_q       <= req_any ? req_lvl : 3'h7;
      ack_cnt_q       <= 2'h1;
      bus_data_q      <= upm16 ? 8'h00 : `PIC_CALL_OPCODE;
      bus_data_oe_n_q <= upm16;
    end else if (inta_pulse && ack_cnt_q != 2'h0) begin
      bus_data_q      <= vector;
      bus_data_oe_n_q <= 1'b0;
      ack_cnt_q       <= (upm16 || ack_cnt_q == 2'h2) ? 2'h0 : 2'h2;
    end else
      bus_data_oe_n_q <= 1'b1;
  end

  // ============================================================
  // Interrupt line and readback
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      int_q <= 1'b0;
    else
      int_q <= (init_q == PIC_ST_RUN) && req_any && (ack_cnt_q == 2'h0) && !take;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      readback_select_q <= 1'b0;
    else if (is_w1)
      readback_select_q <= 1'b0;
    else if (is_w3 && cmd.data[`PIC_W3_READBACK_ENABLE_BIT])
      readback_select_q <= cmd.data[`PIC_W3_RIS_BIT];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      rd_data_q <= 8'h00;
    else if (cmd.a0)
      rd_data_q <= mask_bits_q;
    else
      rd_data_q <= readback_select_q ? in_service_register_q
                                     : pending_request_register_q;
  end
endmodule

//--- pic_monitor.sv
module pic_monitor (
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   nrst,
  // Watched ports
  input wire pic_pkg::pic_host_cmd_t cmd,
  input wire logic [7:0]             rd_data_q,
  input wire logic                   inta_pulse,
  input wire logic [7:0]             bus_data_q,
  input wire logic                   bus_data_oe_n_q,
  input wire logic [7:0]             request_input,
  input wire logic                   int_q
);
  timeunit 1ns;
  timeprecision 1ps;
  import pic_pkg::*;
  // ====================
  // Init tracking; single device only, a cascade word would skew it
  logic [1:0] cnt_q;
  logic [7:0] base_q, mask_q;
  logic       upm_q, odd_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 2'h0;
      base_q <= 8'h00;
      mask_q <= 8'hff;
      upm_q <= 1'b0;
    end else if (cmd.wr && !cmd.a0 && cmd.data[4]) begin
      // A fresh init word also clears the mask
      cnt_q <= 2'h1;
      upm_q <= 1'b0;
      mask_q <= 8'h00;
    end else if (cmd.wr && cmd.a0 && cnt_q != 2'h0) begin
      if (cnt_q != 2'h3) cnt_q <= cnt_q + 2'h1;
      if (cnt_q == 2'h1) base_q <= cmd.data;
      if (cnt_q == 2'h2) upm_q <= cmd.data[0];
      if (cnt_q == 2'h3) mask_q <= cmd.data;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) odd_q <= 1'b0;
    else if (cmd.wr && !cmd.a0 && cmd.data[4]) odd_q <= 1'b0;
    else if (inta_pulse && cnt_q == 2'h3) odd_q <= !odd_q;
  end
  // ====================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_oe_one_cycle: assert property (!bus_data_oe_n_q |=> bus_data_oe_n_q)
    else $error("bus held too long");
  a_oe_after_ack: assert property ($fell(bus_data_oe_n_q) |-> $past(inta_pulse))
    else $error("bus driven unasked");
  a_first_quiet: assert property (inta_pulse && upm_q && !odd_q |=> bus_data_oe_n_q)
    else $error("bus driven on first ack");
  a_second_drive: assert property (inta_pulse && upm_q && odd_q |=> !bus_data_oe_n_q)
    else $error("no vector on second ack");
  a_vec_upper: assert property (!bus_data_oe_n_q && upm_q |->
    bus_data_q[7:3] == base_q[7:3]) else $error("vector upper bits wrong");
  a_int_ack_drop: assert property (int_q && inta_pulse |=> !int_q)
    else $error("int held past ack");
  a_mask_read: assert property ($past(nrst) && $past(cmd.a0) && !$past(cmd.wr) |->
    rd_data_q == $past(mask_q)) else $error("mask readback wrong");
  a_mask_blocks: assert property ($rose(int_q) |->
    ($past(request_input, 2) & ~$past(mask_q, 2)) != 8'h00) else $error("masked int");
  cover property (!bus_data_oe_n_q && upm_q);
  cover property ($rose(int_q));
  cover property (cmd.wr && cmd.a0 && cnt_q == 2'h3);
endmodule

//--- pic_host.sv
module pic_host (
  // Clock
  input wire logic             clk,
  // Device answers
  input wire logic [7:0]       rd_data_q,
  input wire logic [7:0]       bus_data_q,
  // Host requests
  output pic_pkg::pic_host_cmd_t cmd,
  output logic                 inta_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  import pic_pkg::*;
  initial begin
    cmd = '0;
    inta_pulse = 1'b0;
  end
  // ====================
  // Host cycles, all launched on a rising edge
  task automatic put(input logic a0, input logic [7:0] d);
    cmd <= '{1'b1, 1'b0, a0, d};
    @(posedge clk);
    cmd <= '{1'b0, 1'b0, a0, ~d}; // Released data never echoes the last byte
    @(posedge clk);
  endtask
  task automatic setup(input logic [7:0] base, input logic [7:0] w4, input logic [7:0] m);
    put(1'b0, 8'h13);
    put(1'b1, base);
    put(1'b1, w4);
    put(1'b1, m);
  endtask
  task automatic rd(input logic a0, output logic [7:0] v);
    cmd.a0 <= a0;
    repeat (2) @(posedge clk);
    #1 v = rd_data_q;
    @(posedge clk);
  endtask
  task automatic ack2(input int dly, output logic [7:0] v);
    repeat (dly) @(posedge clk);
    inta_pulse <= 1'b1;
    @(posedge clk);
    inta_pulse <= 1'b0;
    @(posedge clk);
    inta_pulse <= 1'b1;
    @(posedge clk);
    inta_pulse <= 1'b0;
    #1 v = bus_data_q;
    @(posedge clk);
  endtask
endmodule

//--- pic_tb.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pic_pkg::*;
  logic          clk = 1'b0;
  logic          nrst, inta_pulse, int_q, oe_n;
  logic [7:0]    req, rd_data_q, bus_data_q, v;
  pic_host_cmd_t cmd;
  int            errors, n_compared, seed, k;
  int            exp_q[$];
  always #5 clk = ~clk;
  pic_top uut (.clk(clk), .nrst(nrst), .cmd(cmd), .rd_data_q(rd_data_q),
    .inta_pulse(inta_pulse), .bus_data_q(bus_data_q), .bus_data_oe_n_q(oe_n),
    .request_input(req), .int_q(int_q));
  pic_host host (.clk(clk), .rd_data_q(rd_data_q), .bus_data_q(bus_data_q),
    .cmd(cmd), .inta_pulse(inta_pulse));
  // ====================
  // Checking
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask
  task automatic conclude();
    if (errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_int();
    for (k = 0; k < 20 && int_q !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    if (k == 20) begin
      errors++;
      conclude();
    end
    @(posedge clk);
  endtask
  // ====================
  // Sequence
  initial begin
    seed = 28;
    errors = 0;
    n_compared = 0;
    nrst = 1'b0;
    req = 8'h00;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    host.rd(1'b1, v);
    chk_byte(v, 8'hff);
    host.setup(8'h48, 8'h03, 8'he0);
    host.rd(1'b1, v);
    chk_byte(v, 8'he0);
    for (int lvl = 0; lvl < 5; lvl++) begin
      exp_q.push_back((8'h48 & 8'hf8) | lvl);
      req[lvl] <= 1'b1;
      wait_int();
      host.put(1'b0, 8'h0a);
      host.rd(1'b0, v);
      chk_byte(v, 8'h01 << lvl);
      host.ack2(lvl, v); // Growing delay exercises slow acknowledges
      chk_byte(v, 8'(exp_q.pop_front()));
      host.put(1'b0, 8'h0b);
      host.rd(1'b0, v);
      chk_byte(v, 8'h00);
      repeat (8) @(posedge clk);
      #1 chk_bit(int_q, 1'b0);
      @(posedge clk);
      req[lvl] <= 1'b0;
    end
    for (k = 0; k < 24; k++) begin
      req[7:5] <= 3'($random(seed));
      @(posedge clk);
      #1 chk_bit(int_q, 1'b0);
      @(posedge clk);
    end
    // Nested mode without auto end-of-interrupt, rotation by commands
    req <= 8'h00;
    host.setup(8'h20, 8'h01, 8'h00);
    req[2] <= 1'b1;
    wait_int();
    host.ack2(0, v);
    chk_byte(v, 8'h22);
    host.put(1'b0, 8'h0b);
    host.rd(1'b0, v);
    chk_byte(v, 8'h04);
    host.put(1'b0, 8'ha0);
    host.rd(1'b0, v);
    chk_byte(v, 8'h00);
    req[2] <= 1'b0;
    @(posedge clk);
    req <= 8'h0c;
    wait_int();
    host.ack2(0, v);
    chk_byte(v, 8'h23);
    host.put(1'b0, 8'he3);
    host.rd(1'b0, v);
    chk_byte(v, 8'h00);
    wait_int();
    host.ack2(0, v);
    chk_byte(v, 8'h22);
    host.rd(1'b0, v);
    chk_byte(v, 8'h04);
    host.put(1'b0, 8'h20);
    host.rd(1'b0, v);
    chk_byte(v, 8'h00);
    conclude();
  end
endmodule

bind pic_top pic_monitor mon (.clk(clk), .nrst(nrst), .cmd(cmd), .rd_data_q(rd_data_q),
  .inta_pulse(inta_pulse), .bus_data_q(bus_data_q), .bus_data_oe_n_q(bus_data_oe_n_q),
  .request_input(request_input), .int_q(int_q));
